// [rtl/afr_pkg.sv]
// Shared constants and types for the conversion frame readout block
package afr_pkg;
    // Frame geometry
    localparam int          NUM_CH     = 8;
    localparam int          STATUS_W   = 24;
    localparam int          CH_W_FULL  = 24;
    localparam int          CH_W_SHORT = 16;
    localparam int          FRAME_MAX  = 216;
    localparam int          RAW_W      = 26;
    localparam logic [3:0]  STATUS_HDR = 4'h0;
    // Channel count selection
    localparam logic [1:0]  NCH_SEL_4  = 2'h0;
    localparam logic [1:0]  NCH_SEL_6  = 2'h1;
    localparam logic [2:0]  NCH_4      = 3'h4;
    localparam logic [2:0]  NCH_6      = 3'h6;
    localparam logic [2:0]  NCH_8      = 3'h0; // 0 means all eight
    // Rate select codes and low-bit masks for reduced resolution
    localparam logic [2:0]  RATE_FAST0 = 3'h0;
    localparam logic [2:0]  RATE_FAST1 = 3'h1;
    localparam logic [23:0] MASK_17BIT = 24'hFFFF80;
    localparam logic [23:0] MASK_19BIT = 24'hFFFFE0;
    // Saturation codes
    localparam logic [23:0] SAT_POS    = 24'h7FFFFF;
    localparam logic [23:0] SAT_NEG    = 24'h800000;
    localparam logic signed [RAW_W-1:0] RAW_POS_LIM = 26'sh07FFFFF;
    localparam logic signed [RAW_W-1:0] RAW_NEG_LIM = -26'sh0800000;
    // Opcodes recognised on the serial port
    localparam logic [7:0]  CMD_START_OP = 8'h08;
    localparam logic [7:0]  CMD_STOP_OP  = 8'h0A;
    localparam logic [7:0]  CMD_RDATA_OP = 8'h12;
    // Timing, in master clock periods and nanoseconds
    localparam int          MASTER_CLK_PERIOD_NS = 50;
    localparam int          SYS_CLK_PERIOD_NS    = 50;
    localparam int          START_MIN_MASTER_CLOCK_PERIOD       = 2;
    localparam int          STOP_SETUP_MASTER_CLOCK_PERIOD      = 16;
    localparam int          START_MIN_CYC  = (START_MIN_MASTER_CLOCK_PERIOD * MASTER_CLK_PERIOD_NS
                                              + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int          STOP_SETUP_CYC = (STOP_SETUP_MASTER_CLOCK_PERIOD * MASTER_CLK_PERIOD_NS
                                              + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int          TIMER_W = 16;

    typedef logic [NUM_CH-1:0][RAW_W-1:0] afr_raw_set_t;

    typedef struct packed {
        logic [7:0] leadoff_pos_status;
        logic [7:0] leadoff_neg_status;
        logic [3:0] gpio;
    } afr_status_t;

    typedef struct packed {
        logic              single_shot;
        logic              low_power;
        logic [2:0]        rate_select;
        logic              multi_readback;
        logic              read_continuous_cmd;
        logic [1:0]        chan_sel;
        logic [NUM_CH-1:0] chan_pd;
    } afr_cfg_t;

    typedef struct packed {
        logic [FRAME_MAX-1:0] frame;
        logic [7:0]           len;
    } afr_snap_t;

    typedef enum logic [1:0] {AFR_IDLE, AFR_CONV, AFR_HELD} afr_sys_st_t;
endpackage

// [rtl/afr_sync2.sv]
// Two-flop level synchroniser
`timescale 1ns/1ns
module afr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,     // Destination clock
    input  wire logic         i_reset_n, // Async reset, active low
    input  wire logic [W-1:0] i_async,   // Level from another domain
    output logic      [W-1:0] o_sync     // Synchronised level
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// [rtl/afr_frame_ctrl.sv]
// Conversion sequencing and serial frame readout
`timescale 1ns/1ns
// Behaviour
// - Drive conv_done_n low when a new result set is ready.
// - First SCLK falling edge raises conv_done_n, regardless of chip select, except while a single-shot result is held.
// - On-demand read stays intact if the next result lands mid-read.
// - DOUT changes on SCLK rising edges, MSB on the first edge.
// - Frame is status word then channels ascending; every channel keeps its slot.
// - Powered-down channels read as zero in their slot.
// - Status word is 24 bits: lead-off positive, lead-off negative, GPIO bits.
// - Two fastest rates use 16-bit words outside low-power mode, else 24-bit; 4, 6 or 8 channels.
// - With multiple readback set, extra SCLKs repeat the frame from its start.
// - Channel words are two's complement, saturating at 7FFFFF and 800000.
// - Rate codes 000 and 001 give 17 and 19 meaningful bits.
// - Single-shot mode runs one conversion per start edge or start command.
// - Single-shot completion holds conv_done_n low and halts conversions.
// - Each single-shot start resets the filter, so full settling applies.
// - Continuous mode starts on start pin or command, results until stopped.
// - A stop lets the conversion in progress complete.
// - Start and stop opcodes act on the seventh SCLK falling edge.
// - Single-shot versus continuous is chosen by a configuration bit.
module afr_frame_ctrl #(
    parameter int SETTLE_BASE_CYC = 296, // Settling periods at rate code 000
    parameter int PERIOD_BASE_CYC = 64   // Result spacing at rate code 000
) (
    input  wire logic                  i_clk_sys,      // Master clock, 20 MHz
    input  wire logic                  i_reset_n,      // Async reset, active low
    input  wire afr_pkg::afr_cfg_t     i_cfg,          // Static configuration
    input  wire afr_pkg::afr_raw_set_t i_chan_raw,     // Filter outputs, signed
    input  wire afr_pkg::afr_status_t  i_status,       // Status word contents
    input  wire logic                  i_start_pin,    // Start pin, asynchronous
    input  wire logic                  i_sclk,         // Serial clock from host
    input  wire logic                  i_cs_n,         // Chip select, active low
    input  wire logic                  i_din,          // Serial data in
    output logic                       o_dout,         // Serial data out value
    output logic                       o_dout_oe,      // DOUT drive enable
    output logic                       o_conv_done_n,  // Results ready, active low
    output logic                       o_converting    // Conversion sequence active
);
    // System-domain state
    typedef struct packed {
        afr_pkg::afr_sys_st_t      st;
        logic [afr_pkg::TIMER_W-1:0] timer;
        logic [1:0]                hi_cnt;
        logic                      start_prev;
        logic                      start_tgl_prev;
        logic                      stop_tgl_prev;
        logic                      stop_pend;
        logic                      stop_late;
        logic                      conv_done_n;
        logic                      arm_clr;
        logic                      arm_wait;
        afr_pkg::afr_snap_t        latest;
        afr_pkg::afr_snap_t        shadow;
    } afr_sys_t;

    // Readout state, SCLK rising edge, cleared by chip select high
    typedef struct packed {
        logic [7:0] cnt;
        logic       done;
        logic       dout;
    } afr_tx_t;

    // Opcode capture, SCLK falling edge, cleared by chip select high
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] sh;
        logic       rdata;
    } afr_rx_t;

    // Opcode event toggles, survive chip select
    typedef struct packed {
        logic start_tgl;
        logic stop_tgl;
    } afr_tgl_t;

    afr_sys_t sys_q, sys_d;
    afr_tx_t  tx_q, tx_d;
    afr_rx_t  rx_q, rx_d;
    afr_tgl_t tgl_q, tgl_d;
    logic     fell_q;
    logic     fell_rst_n;
    logic     serial_rst_n;
    logic     start_s, cs_n_s, fell_s, start_tgl_s, stop_tgl_s;
    logic     rd_active;

    // Clamp a wide filter value to 24 bits
    function automatic logic [23:0] sat24(input logic signed [afr_pkg::RAW_W-1:0] x);
        logic [23:0] r;
        r = x[23:0];
        if (x > afr_pkg::RAW_POS_LIM) begin
            r = afr_pkg::SAT_POS;
        end else if (x < afr_pkg::RAW_NEG_LIM) begin
            r = afr_pkg::SAT_NEG;
        end
        return r;
    endfunction

    // Settling or result spacing for the current rate code
    function automatic logic [afr_pkg::TIMER_W-1:0] rate_cyc(input int base,
                                                             input logic [2:0] rate);
        int v;
        v = (base * afr_pkg::MASTER_CLK_PERIOD_NS / afr_pkg::SYS_CLK_PERIOD_NS) << rate;
        return afr_pkg::TIMER_W'(v - 1);
    endfunction

    // Assemble one frame, MSB aligned, from the current filter outputs
    function automatic afr_pkg::afr_snap_t build_snap(input afr_pkg::afr_raw_set_t raw,
                                                      input afr_pkg::afr_status_t stat,
                                                      input afr_pkg::afr_cfg_t cfg);
        afr_pkg::afr_snap_t s;
        logic [23:0]        w;
        logic               short_w;
        logic [2:0]         nch;
        s = '0;
        short_w = !cfg.low_power && (cfg.rate_select == afr_pkg::RATE_FAST0 ||
                                     cfg.rate_select == afr_pkg::RATE_FAST1);
        nch = (cfg.chan_sel == afr_pkg::NCH_SEL_4) ? afr_pkg::NCH_4 :
              (cfg.chan_sel == afr_pkg::NCH_SEL_6) ? afr_pkg::NCH_6 : afr_pkg::NCH_8;
        s.frame[afr_pkg::FRAME_MAX-1 -: afr_pkg::STATUS_W] = {afr_pkg::STATUS_HDR,
            stat.leadoff_pos_status, stat.leadoff_neg_status, stat.gpio};
        for (int c = 0; c < afr_pkg::NUM_CH; c++) begin
            w = sat24(raw[c]);
            if (cfg.chan_pd[c]) begin
                w = '0;
            end
            // drop bits beyond the usable resolution
            if (cfg.rate_select == afr_pkg::RATE_FAST0) begin
                w = w & afr_pkg::MASK_17BIT;
            end else if (cfg.rate_select == afr_pkg::RATE_FAST1) begin
                w = w & afr_pkg::MASK_19BIT;
            end
            // ascending slots; packed with no gaps
            if (nch == afr_pkg::NCH_8 || 3'(c) < nch) begin
                if (short_w) begin
                    s.frame[afr_pkg::FRAME_MAX-1-afr_pkg::STATUS_W-c*afr_pkg::CH_W_SHORT
                            -: afr_pkg::CH_W_SHORT] = w[23 -: afr_pkg::CH_W_SHORT];
                end else begin
                    s.frame[afr_pkg::FRAME_MAX-1-afr_pkg::STATUS_W-c*afr_pkg::CH_W_FULL
                            -: afr_pkg::CH_W_FULL] = w;
                end
            end
        end
        // frame length follows word width and channel count
        case (nch)
            afr_pkg::NCH_4: s.len = short_w ? 8'h58 : 8'h78;
            afr_pkg::NCH_6: s.len = short_w ? 8'h78 : 8'hA8;
            default:        s.len = short_w ? 8'h98 : 8'hD8;
        endcase
        return s;
    endfunction

    // Bring pins and SCLK-side events into the system domain
    afr_sync2 #(.W(5)) u_sync (
        .i_clk     (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   ({i_start_pin, i_cs_n, fell_q, tgl_q.start_tgl, tgl_q.stop_tgl}),
        .o_sync    ({start_s, cs_n_s, fell_s, start_tgl_s, stop_tgl_s})
    );

    // Conversion sequencer and result buffering
    always_comb begin
        logic go;
        logic halt;
        logic result;
        go     = 1'b0;
        halt   = 1'b0;
        result = 1'b0;
        sys_d  = sys_q;
        sys_d.arm_clr        = 1'b0;
        sys_d.start_prev     = start_s;
        sys_d.start_tgl_prev = start_tgl_s;
        sys_d.stop_tgl_prev  = stop_tgl_s;
        // Start pin must stay high for the minimum time before it counts
        if (!start_s) begin
            sys_d.hi_cnt = '0;
        end else if (sys_q.hi_cnt != 2'(afr_pkg::START_MIN_CYC)) begin
            sys_d.hi_cnt = sys_q.hi_cnt + 2'h1;
        end
        // start on qualified pin level or start opcode
        go = (start_s && sys_q.hi_cnt == 2'(afr_pkg::START_MIN_CYC - 1))
             || (start_tgl_s != sys_q.start_tgl_prev);
        halt = (!start_s && sys_q.start_prev) || (stop_tgl_s != sys_q.stop_tgl_prev);
        // falling SCLK raises the flag once the arm has settled
        if (!fell_s) begin
            sys_d.arm_wait = 1'b0;
        end
        // a held single-shot result keeps the flag low
        if (fell_s && !sys_q.arm_wait && sys_q.st != afr_pkg::AFR_HELD) begin
            sys_d.conv_done_n = 1'b1;
        end
        case (sys_q.st)
            afr_pkg::AFR_IDLE, afr_pkg::AFR_HELD: begin
                if (go) begin
                    // each start restarts full filter settling
                    sys_d.st          = afr_pkg::AFR_CONV;
                    sys_d.timer       = rate_cyc(SETTLE_BASE_CYC, i_cfg.rate_select);
                    sys_d.conv_done_n = 1'b1;
                    sys_d.stop_pend   = 1'b0;
                    sys_d.stop_late   = 1'b0;
                end
            end
            afr_pkg::AFR_CONV: begin
                if (go) begin
                    sys_d.timer     = rate_cyc(SETTLE_BASE_CYC, i_cfg.rate_select);
                    sys_d.stop_pend = 1'b0;
                    sys_d.stop_late = 1'b0;
                end else begin
                    if (halt) begin
                        // too close to a result lets one more run
                        if (sys_q.timer >= afr_pkg::TIMER_W'(afr_pkg::STOP_SETUP_CYC)) begin
                            sys_d.stop_pend = 1'b1;
                        end else begin
                            sys_d.stop_late = 1'b1;
                        end
                    end
                    if (sys_q.timer == '0) begin
                        result = 1'b1;
                    end else begin
                        sys_d.timer = sys_q.timer - 1'b1;
                    end
                end
                if (result) begin
                    sys_d.timer = rate_cyc(PERIOD_BASE_CYC, i_cfg.rate_select);
                    // one conversion per start in single-shot mode
                    // mode taken from the configuration bit
                    if (i_cfg.single_shot) begin
                        sys_d.st = afr_pkg::AFR_HELD;
                    // halt only once the running conversion is done
                    end else if (sys_q.stop_pend || (halt && sys_q.timer >=
                                 afr_pkg::TIMER_W'(afr_pkg::STOP_SETUP_CYC))) begin
                        sys_d.st        = afr_pkg::AFR_IDLE;
                        sys_d.stop_pend = 1'b0;
                    end else if (sys_q.stop_late || halt) begin
                        sys_d.stop_pend = 1'b1;
                        sys_d.stop_late = 1'b0;
                    end
                end
            end
            default: begin
                sys_d.st = afr_pkg::AFR_IDLE;
            end
        endcase
        // new results pull the flag low, winning over a clear
        if (result) begin
            sys_d.latest      = build_snap(i_chan_raw, i_status, i_cfg);
            sys_d.conv_done_n = 1'b0;
            sys_d.arm_clr     = 1'b1;
            sys_d.arm_wait    = 1'b1;
        end
        // the readout copy is frozen while chip select is low
        if (cs_n_s) begin
            sys_d.shadow = sys_q.latest;
        end
    end

    // System-domain register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sys_q             <= '0;
            sys_q.st          <= afr_pkg::AFR_IDLE;
            sys_q.conv_done_n <= 1'b1;
        end else begin
            sys_q <= sys_d;
        end
    end

    // Chip select high resets the serial side
    assign serial_rst_n = i_reset_n && !i_cs_n;
    assign rd_active    = i_cfg.read_continuous_cmd || rx_q.rdata;

    // Serial readout on rising SCLK
    always_comb begin
        tx_d = tx_q;
        if (rd_active && !tx_q.done) begin
            // next frame bit leaves on each rising edge, MSB first
            tx_d.dout = sys_q.shadow.frame[afr_pkg::FRAME_MAX - 1 - int'(tx_q.cnt)];
            if (tx_q.cnt == sys_q.shadow.len - 8'h01) begin
                tx_d.cnt = '0;
                // multiple readback wraps to the first byte
                tx_d.done = !i_cfg.multi_readback;
            end else begin
                tx_d.cnt = tx_q.cnt + 8'h01;
            end
        end else begin
            tx_d.dout = 1'b0;
        end
    end

    // Readout register, link clock
    always_ff @(posedge i_sclk or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    // Opcode capture on falling SCLK
    always_comb begin
        logic [6:0] first7;
        first7 = {rx_q.sh[5:0], i_din};
        rx_d   = rx_q;
        tgl_d  = tgl_q;
        // DIN is not decoded while a frame is read
        if (!rd_active) begin
            rx_d.sh      = first7;
            rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
            // start and stop act on the seventh falling edge
            if (rx_q.bit_cnt == 3'h6) begin
                if (first7 == afr_pkg::CMD_START_OP[7:1]) begin
                    tgl_d.start_tgl = !tgl_q.start_tgl;
                end
                if (first7 == afr_pkg::CMD_STOP_OP[7:1]) begin
                    tgl_d.stop_tgl = !tgl_q.stop_tgl;
                end
            end
            if (rx_q.bit_cnt == 3'h7 && {rx_q.sh, i_din} == afr_pkg::CMD_RDATA_OP) begin
                rx_d.rdata = 1'b1;
            end
        end
    end

    // Opcode registers, link clock
    always_ff @(negedge i_sclk or negedge serial_rst_n) begin
        if (!serial_rst_n) begin
            rx_q <= '0;
        end else begin
            rx_q <= rx_d;
        end
    end

    // Event toggles must not be reset by chip select, or a false event appears
    always_ff @(negedge i_sclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tgl_q <= '0;
        end else begin
            tgl_q <= tgl_d;
        end
    end

    // Each new result re-arms the falling-edge detector
    assign fell_rst_n = i_reset_n && !sys_q.arm_clr;

    // any falling SCLK marks the flag for clearing, chip select ignored
    always_ff @(negedge i_sclk or negedge fell_rst_n) begin
        if (!fell_rst_n) begin
            fell_q <= 1'b0;
        end else begin
            fell_q <= 1'b1;
        end
    end

    // Outputs
    assign o_dout        = tx_q.dout;
    assign o_dout_oe     = !i_cs_n;
    assign o_conv_done_n = sys_q.conv_done_n;
    assign o_converting  = (sys_q.st == afr_pkg::AFR_CONV);
endmodule

// [bench/afr_frame_ctrl_sva.sv]
// Port-level checker for the frame readout control
`timescale 1ns/1ns
module afr_frame_ctrl_sva (
    input wire logic              i_clk_sys,     // Master clock
    input wire logic              i_reset_n,     // Reset, active low
    input wire afr_pkg::afr_cfg_t i_cfg,         // Configuration
    input wire logic              i_start_pin,   // Start pin
    input wire logic              i_cs_n,        // Chip select, active low
    input wire logic              o_dout,        // Serial data out
    input wire logic              o_conv_done_n, // Results ready, active low
    input wire logic              o_converting   // Conversion active
);
    // All checks live in the master clock domain
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    AST_START_HI: assert property ($rose(o_converting) |-> o_conv_done_n)
        else $error("ready flag low when conversions start");
    AST_DONE_SRC: assert property ($fell(o_conv_done_n) |-> $past(o_converting))
        else $error("ready flag fell with no conversion running");
    AST_SS_HALT: assert property (i_cfg.single_shot && $fell(o_conv_done_n)
        |-> !o_converting) else $error("single-shot did not halt");
    AST_SS_HOLD: assert property (i_cfg.single_shot && $fell(o_conv_done_n)
        |=> (!o_conv_done_n)[*8]) else $error("single-shot ready flag not held");
    AST_STOP_END: assert property ($fell(o_converting) |-> !o_conv_done_n)
        else $error("conversions halted before a result");
    AST_PIN_GO: assert property (!o_converting && i_cs_n && $rose(i_start_pin)
        ##1 i_start_pin[*5] |-> o_converting) else $error("start pin ignored");
    AST_PIN_SHORT: assert property (!o_converting && i_cs_n && $rose(i_start_pin)
        ##1 (!i_start_pin)[*6] |-> !o_converting) else $error("short start pulse taken");
    AST_DOUT_IDLE: assert property (i_cs_n && $past(i_cs_n) |-> !o_dout)
        else $error("data out active while deselected");
endmodule
bind afr_frame_ctrl afr_frame_ctrl_sva u_sva (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_cfg(i_cfg), .i_start_pin(i_start_pin), .i_cs_n(i_cs_n), .o_dout(o_dout),
    .o_conv_done_n(o_conv_done_n), .o_converting(o_converting));

// [bench/afr_host_model.sv]
// Serial host model: runs SCLK with chip select low, or high when sel is 0, and captures DOUT
`timescale 1ns/1ns
module afr_host_model (
    output logic      o_sclk,   // Serial clock, still outside frames
    output logic      o_cs_n,   // Chip select, active low
    output logic      o_din,    // Opcode bits to the device
    input  wire logic i_dout,   // Device data out
    input  wire logic i_dout_oe // Device drive enable
);
    logic [255:0] rx;   // Captured bits, newest in bit 0
    logic         last; // Last level seen on the line
    // Undriven line shows the inverse of its last level
    wire          line = i_dout_oe ? i_dout : ~last;
    // Idle levels
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
        last   = 1'b0;
    end
    task automatic xfer(input int n, input logic [7:0] op, input bit sel);
        rx = '0;
        #11 o_cs_n = !sel;
        #250;
        for (int i = 0; i < n; i++) begin
            o_din  = (i < 8) ? op[7 - i] : 1'b0;
            o_sclk = 1'b1;
            #32 o_sclk = 1'b0;
            rx   = {rx[254:0], line};
            last = line;
            #32;
        end
        #250 o_cs_n = 1'b1; // Keeps over five master periods after the last edge
    endtask
endmodule

// [bench/afr_frame_ctrl_tb.sv]
// Self-checking bench for the frame readout control
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module afr_frame_ctrl_tb;
    localparam logic [3:0][25:0] CORNER = {26'h0000001, 26'h2000000, 26'h0800000, 26'h1FFFFFF};
    logic                  i_clk_sys, i_reset_n, i_start_pin;
    afr_pkg::afr_cfg_t     cfg;
    afr_pkg::afr_raw_set_t raw;
    afr_pkg::afr_status_t  stat;
    logic                  sclk, cs_n, din, dout, oe, done_n, conv;
    int                    miscompares, checks;
    logic [31:0]           seed = 32'h00017920; // Start value 96544
    // Short settling counts keep the run brief
    afr_frame_ctrl #(.SETTLE_BASE_CYC(8), .PERIOD_BASE_CYC(32)) uut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cfg(cfg), .i_chan_raw(raw),
        .i_status(stat), .i_start_pin(i_start_pin), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .o_dout(dout), .o_dout_oe(oe), .o_conv_done_n(done_n),
        .o_converting(conv));
    afr_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
        .i_dout_oe(oe));
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected frame, right-justified, then 24 bits of replay or zeros
    function automatic logic [255:0] frame_of(output int len);
        logic [255:0] f;
        logic [23:0]  w;
        int           n, wb;
        n  = (cfg.chan_sel == 2'h0) ? 4 : (cfg.chan_sel == 2'h1) ? 6 : 8;
        wb = (cfg.rate_select < 3'h2 && !cfg.low_power) ? 16 : 24;
        f  = {afr_pkg::STATUS_HDR, stat};
        for (int c = 0; c < n; c++) begin
            w = raw[c][23:0];
            if ($signed(raw[c]) > afr_pkg::RAW_POS_LIM) w = afr_pkg::SAT_POS;
            if ($signed(raw[c]) < afr_pkg::RAW_NEG_LIM) w = afr_pkg::SAT_NEG;
            if (cfg.rate_select == 3'h0) w &= afr_pkg::MASK_17BIT;
            if (cfg.rate_select == 3'h1) w &= afr_pkg::MASK_19BIT;
            if (cfg.chan_pd[c]) w = '0;
            f = (wb == 16) ? {f[239:0], w[23:8]} : {f[231:0], w};
        end
        len = 24 + n * wb;
        f = {f[231:0], cfg.multi_readback ? {afr_pkg::STATUS_HDR, stat} : 24'h0};
        return f;
    endfunction
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1; // Let the edge's updates land
    endtask
    // Bounded wait for halt (idle=1) or for a result; running out is a mismatch
    task automatic wait_for(input bit idle);
        int i;
        for (i = 0; i < 3000; i++) begin
            cyc(1);
            if (idle ? conv === 1'b0 : done_n === 1'b0) break;
        end
        if (i == 3000) miscompares++;
    endtask
    // Master clock, 50 ns
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    // Watchdog, well past the expected run length
    initial begin
        #3000000;
        miscompares++;
        close_out();
    end
    // Main sequence: even passes continuous by pin, odd passes single-shot by opcode
    initial begin
        int           len;
        logic [31:0]  r;
        logic [255:0] want;
        i_reset_n = 1'b0;
        i_start_pin = 1'b0;
        cfg = '0;
        raw = '0;
        stat = '0;
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        cyc(3);
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk_sys);
            r = rnd();
            cfg <= '{single_shot: k[0], low_power: (k >= 4), rate_select: k[1:0],
                     multi_readback: k[1], read_continuous_cmd: !k[0],
                     chan_sel: k % 3, chan_pd: r[7:0]};
            stat <= r[31:12];
            for (int c = 0; c < 8; c++) begin
                r = rnd();
                raw[c] <= (c < 4 && !k[0]) ? CORNER[c] : {{3{r[22]}}, r[22:0]};
            end
            if (!k[0]) begin
                i_start_pin <= 1'b1;
                @(posedge i_clk_sys) i_start_pin <= 1'b0;
                cyc(8);
                `CHK("short start", 1'b0, conv)
                @(posedge i_clk_sys) i_start_pin <= 1'b1;
                cyc(6);
                `CHK("running", 2'h3, {conv, done_n})
                wait_for(0);
                `CHK("result", 1'b0, done_n)
                cyc(3);
                host.xfer(1, 8'h00, 0);
                cyc(3);
                `CHK("flag cleared", 1'b1, done_n)
                `CHK("oe idle", 1'b0, oe)
                wait_for(0);
                exp_chk_cont : begin
                    want = frame_of(len);
                    fork
                        host.xfer(len + 24, 8'h00, 1);
                        begin
                            repeat (4) @(posedge i_clk_sys);
                            raw <= ~raw;
                            `CHK("oe on", 1'b1, oe)
                        end
                    join
                    `CHK("frame", want, host.rx)
                end
                @(posedge i_clk_sys) i_start_pin <= 1'b0;
                wait_for(1);
                `CHK("halted", 1'b0, done_n)
            end else begin
                host.xfer(8, afr_pkg::CMD_START_OP, 1);
                cyc(1);
                `CHK("opcode start", 1'b1, conv)
                wait_for(0);
                `CHK("single done", 1'b0, conv)
                want = frame_of(len); // Also sets the frame length
                host.xfer(len + 32, afr_pkg::CMD_RDATA_OP, 1);
                `CHK("frame", want, host.rx)
                `CHK("flag held", 1'b0, done_n)
            end
        end
        close_out();
    end
endmodule
